// [verilog/fsw_pkg.sv]
// Constants shared by the flash self-write controller and its memory.
// Assumes a 200 MHz system clock and an 8-bit special function register bus.
`default_nettype none
package fsw_pkg;
  // Clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Special function register addresses.
  localparam logic [7:0] AREA_UNLOCK_ADDR  = 8'h97;
  localparam logic [7:0] WRITE_UNLOCK_ADDR = 8'hC9;
  localparam logic [7:0] AUX_TWO_ADDR      = 8'hF7;

  // Command values.
  localparam logic [7:0] AREA_UNLOCK_KEY   = 8'h65;
  localparam logic [7:0] FLASH_WRITE_KEY   = 8'h47;
  localparam logic [7:0] EEPROM_WRITE_KEY  = 8'hE2;

  // Field positions.
  localparam int unsigned WHOLE_AREA_BIT   = 0;
  localparam int unsigned FLASH_WE_BIT     = 7;
  localparam int unsigned TIMEOUT_BIT      = 6;
  localparam int unsigned EEPROM_WE_BIT    = 5;
  localparam int unsigned TSEL_LSB         = 1;
  localparam int unsigned LOWER_LOCK_BIT   = 1;

  // Reset values; bit 3 of the auxiliary register is not implemented.
  localparam logic [7:0] AUX_TWO_RESET     = 8'h06;
  localparam logic [7:0] AUX_TWO_MASK      = 8'hF7;

  // Flash map boundaries.
  localparam logic [15:0] LOCK_AREA_END    = 16'h01FF;
  localparam logic [15:0] MAIN_AREA_END    = 16'h3EFF;
  localparam logic [15:0] FREE_AREA_END    = 16'h3FEF;
  localparam logic [15:0] CFG_OPEN_END     = 16'h3FF7;
  localparam logic [15:0] WRITE_TOP        = 16'h3FFE;
  localparam logic [15:0] CFG_HIGH_ADDR    = 16'h3FFF;

  // Program and timeout times in nanoseconds.
  localparam int unsigned PROG_TIME_NS     = 1000000;
  localparam int unsigned TO1_TIME_NS      = 1500000;
  localparam int unsigned TO2_TIME_NS      = 5800000;
  localparam int unsigned TO3_TIME_NS      = 11700000;
  // The period is reduced to nanoseconds first so that the longest timeout
  // stays inside 32 bits; the period must therefore be whole nanoseconds.
  localparam int unsigned PROG_CYC = PROG_TIME_NS / (CLK_PERIOD_PS / 1000);
  localparam int unsigned TO1_CYC  = TO1_TIME_NS / (CLK_PERIOD_PS / 1000);
  localparam int unsigned TO2_CYC  = TO2_TIME_NS / (CLK_PERIOD_PS / 1000);
  localparam int unsigned TO3_CYC  = TO3_TIME_NS / (CLK_PERIOD_PS / 1000);

  typedef enum logic {FSW_IDLE, FSW_PROG} fsw_state_e;
endpackage
`default_nettype wire

// [verilog/fsw_mem.sv]
// Byte-wide flash array with one write port and two registered read ports.
// The third registered output shows the top configuration byte at all times.
`timescale 1ns/100ps
`default_nettype none
module fsw_mem #(
  parameter int unsigned AW = 14
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_a_i,
  output logic      [7:0]    rdata_a_o,
  input  wire logic [AW-1:0] raddr_b_i,
  output logic      [7:0]    rdata_b_o,
  output logic      [7:0]    cfg_o
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Array storage has no reset; flash contents survive a system reset.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem[raddr_a_i];
    rdata_b_o <= mem[raddr_b_i];
    cfg_o     <= mem[{AW{1'b1}}];
  end
endmodule
`default_nettype wire

// [verilog/fsw_ctrl.sv]
// Flash self-write controller: unlock registers, sector gating, timed writes.
// Assumes the core presents one access per cycle, holds still while
// CPU_WAIT_O is high, and takes read data on the cycle after the request.
//
// Behaviour
// - Data store to flash address up to 3FFEh writes the accumulator byte.
// - Stores are accepted only while the flash write flag is set.
// - Accepted write lasts about one millisecond with the core held waiting.
// - Only the core is stalled; peripherals and interrupts keep running.
// - Data and code reads return the stored byte with no wait.
// - Lower code lock bit from the top configuration byte restricts low area.
// - Writing 65h to 97h sets whole-area flag; other values clear it.
// - Bit 0 of 97h reads whole-area flag, reset 0, not combined with lock.
// - 47h to C9h sets flash flag, E2h eeprom flag, else both clear.
// - C9h bit 7 reads flash write flag; both flags reset to 0.
// - Timeout flag bit 6 set on timeout, cleared when write flags drop.
// - Timeout select 00 off, else 1.5, 5.8, 11.7 ms then abandon write.
// - Low 512 bytes: lock blocks all; unlocked code reads; flag adds data.
// - Data writes to 0200h..3EFFh need the whole-area flag.
// - Free area 3F00h..3FF7h always open to the data path.
// - Top config byte never on data path; low config bytes need flag.
`timescale 1ns/100ps
`default_nettype none
module fsw_ctrl
  import fsw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned TO1_CYCLES  = TO1_CYC,
  parameter int unsigned TO2_CYCLES  = TO2_CYC,
  parameter int unsigned TO3_CYCLES  = TO3_CYC
) (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  input  wire logic        SFR_WR_I,
  output logic      [7:0]  SFR_RDATA_O,
  input  wire logic [15:0] XDATA_ADDR_I,
  input  wire logic [7:0]  XDATA_WDATA_I,
  input  wire logic        XDATA_WR_I,
  input  wire logic        XDATA_RD_I,
  output logic      [7:0]  XDATA_RDATA_O,
  input  wire logic [15:0] CODE_ADDR_I,
  input  wire logic        CODE_RD_I,
  output logic      [7:0]  CODE_RDATA_O,
  input  wire logic        PGM_VOLTAGE_OK_I,
  output logic             CPU_WAIT_O,
  output logic             PROG_BUSY_O
);
  localparam int CW = 23;

  fsw_state_e  state_reg, state_next;
  logic [CW-1:0] cnt_reg;
  logic        area_flag_reg, flash_we_reg, eep_we_reg, timeout_reg;
  logic [7:0]  aux_reg, sfr_rdata_reg;
  logic [13:0] waddr_reg;
  logic [7:0]  wdata_reg;
  logic        xrd_ok_reg, crd_ok_reg;
  logic [7:0]  mem_x, mem_c, cfg_byte;

  // Register decode.
  wire sfr_wr_area  = SFR_WR_I && (SFR_ADDR_I == AREA_UNLOCK_ADDR);
  wire sfr_wr_wen   = SFR_WR_I && (SFR_ADDR_I == WRITE_UNLOCK_ADDR);
  wire sfr_wr_aux   = SFR_WR_I && (SFR_ADDR_I == AUX_TWO_ADDR);
  wire [1:0] tsel   = aux_reg[TSEL_LSB +: 2];
  wire lower_lock   = cfg_byte[LOWER_LOCK_BIT];

  // Sector gating for the data path; the code path is gated only by the lock and the 3FFFh top.
  wire [15:0] xa      = XDATA_ADDR_I;
  wire in_lock_x      = xa <= LOCK_AREA_END;
  wire in_main_x      = !in_lock_x && xa <= MAIN_AREA_END;
  wire in_free_x      = xa > MAIN_AREA_END && xa <= CFG_OPEN_END;
  wire in_cfg_x       = xa > CFG_OPEN_END && xa <= WRITE_TOP;
  wire data_ok =
    (in_lock_x && !lower_lock && area_flag_reg) ||
    (in_main_x && area_flag_reg) ||
    in_free_x ||
    (in_cfg_x && area_flag_reg);
  wire code_ok = (CODE_ADDR_I > LOCK_AREA_END || !lower_lock) &&
                 CODE_ADDR_I <= CFG_HIGH_ADDR;

  // A store starts programming only if unlocked and the sector is open.
  wire idle      = state_reg == FSW_IDLE;
  wire accept    = idle && XDATA_WR_I && flash_we_reg &&
                   data_ok;
  wire cnt_prog  = cnt_reg >= CW'(PROG_CYCLES - 1);
  wire prog_done = !idle && cnt_prog && PGM_VOLTAGE_OK_I;
  logic [CW-1:0] to_lim;
  always_comb begin
    case (tsel)
      2'h1:    to_lim = CW'(TO1_CYCLES - 1);
      2'h2:    to_lim = CW'(TO2_CYCLES - 1);
      default: to_lim = CW'(TO3_CYCLES - 1);
    endcase
  end
  wire timeout_ev = !idle && !prog_done && tsel != 2'h0 &&
                    cnt_reg >= to_lim;

  // Sequencer for one byte write.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FSW_IDLE: if (accept) state_next = FSW_PROG;
      FSW_PROG: if (prog_done || timeout_ev) state_next = FSW_IDLE;
      default:  state_next = FSW_IDLE;
    endcase
  end

  // Only the core waits; nothing else in the chip is gated by this.
  assign CPU_WAIT_O  = !idle;
  assign PROG_BUSY_O = !idle;

  // Core state, counter and latched write target.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= FSW_IDLE;
      cnt_reg   <= '0;
      waddr_reg <= 14'h0000;
      wdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= idle ? '0 : cnt_reg + CW'(1);
      if (accept) begin
        waddr_reg <= xa[13:0];
        wdata_reg <= XDATA_WDATA_I;
      end
    end
  end

  // Unlock flags; a timeout that lands with a flag clear still sets.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      area_flag_reg <= 1'b0;
      flash_we_reg  <= 1'b0;
      eep_we_reg    <= 1'b0;
      timeout_reg   <= 1'b0;
      aux_reg       <= AUX_TWO_RESET;
    end else begin
      if (sfr_wr_area) begin
        area_flag_reg <= SFR_WDATA_I == AREA_UNLOCK_KEY;
      end
      if (sfr_wr_wen) begin
        flash_we_reg <= SFR_WDATA_I == FLASH_WRITE_KEY;
        eep_we_reg   <= SFR_WDATA_I == EEPROM_WRITE_KEY;
      end
      timeout_reg <= timeout_ev ||
                     (timeout_reg && (flash_we_reg || eep_we_reg) &&
                      !(sfr_wr_wen && SFR_WDATA_I != FLASH_WRITE_KEY &&
                        SFR_WDATA_I != EEPROM_WRITE_KEY));
      if (sfr_wr_aux) begin
        aux_reg <= SFR_WDATA_I & AUX_TWO_MASK;
      end
    end
  end

  // Read-back values, registered so the core sees them next cycle.
  logic [7:0] sfr_mux;
  always_comb begin
    sfr_mux = 8'h00;
    case (SFR_ADDR_I)
      AREA_UNLOCK_ADDR: sfr_mux[WHOLE_AREA_BIT] = area_flag_reg;
      WRITE_UNLOCK_ADDR: begin
        sfr_mux[FLASH_WE_BIT]  = flash_we_reg;
        sfr_mux[TIMEOUT_BIT]   = timeout_reg;
        sfr_mux[EEPROM_WE_BIT] = eep_we_reg;
      end
      AUX_TWO_ADDR: sfr_mux = aux_reg;
      default:      sfr_mux = 8'h00;
    endcase
  end

  // Read gating flags; a refused read returns zero instead of code.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sfr_rdata_reg <= 8'h00;
      xrd_ok_reg    <= 1'b0;
      crd_ok_reg    <= 1'b0;
    end else begin
      sfr_rdata_reg <= sfr_mux;
      xrd_ok_reg    <= XDATA_RD_I && (data_ok ||
                       (in_lock_x && !lower_lock && area_flag_reg));
      crd_ok_reg    <= CODE_RD_I && code_ok;
    end
  end

  assign SFR_RDATA_O   = sfr_rdata_reg;
  assign XDATA_RDATA_O = xrd_ok_reg ? mem_x : 8'h00;
  assign CODE_RDATA_O  = crd_ok_reg ? mem_c : 8'h00;

  // Commit happens only at the end of a successful program time.
  fsw_mem #(.AW(14)) u_mem (
    .clk_i     (CLK_I),
    .we_i      (prog_done),
    .waddr_i   (waddr_reg),
    .wdata_i   (wdata_reg),
    .raddr_a_i (xa[13:0]),
    .rdata_a_o (mem_x),
    .raddr_b_i (CODE_ADDR_I[13:0]),
    .rdata_b_o (mem_c),
    .cfg_o     (cfg_byte)
  );

  // Checks.
  property p_wait_on_accept;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    accept |=> CPU_WAIT_O [*2];
  endproperty
  a_wait_on_accept: assert property (p_wait_on_accept)
    else $error("Core not held after accepted store.");

  property p_locked_store;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (idle && XDATA_WR_I && !flash_we_reg) |=> !CPU_WAIT_O;
  endproperty
  a_locked_store: assert property (p_locked_store)
    else $error("Store accepted without write unlock.");

  property p_denied_store;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (idle && XDATA_WR_I && !data_ok) |=> (!CPU_WAIT_O && !prog_done);
  endproperty
  a_denied_store: assert property (p_denied_store)
    else $error("Store to closed sector stalled the core.");

  property p_area_key;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    sfr_wr_area |=> area_flag_reg == $past(SFR_WDATA_I == AREA_UNLOCK_KEY);
  endproperty
  a_area_key: assert property (p_area_key)
    else $error("Whole-area flag does not follow command.");

  property p_write_key;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (sfr_wr_wen && SFR_WDATA_I == FLASH_WRITE_KEY) |=>
      flash_we_reg && !eep_we_reg ##1 SFR_RDATA_O[FLASH_WE_BIT] ||
      $past(SFR_ADDR_I) != WRITE_UNLOCK_ADDR;
  endproperty
  a_write_key: assert property (p_write_key)
    else $error("Flash write key not honoured.");

  property p_timeout_clear;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!flash_we_reg && !eep_we_reg && !timeout_ev) |=> !timeout_reg;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear)
    else $error("Timeout flag stuck with write flags clear.");

  property p_timeout_off;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!idle && tsel == 2'h0 && !prog_done) |=> CPU_WAIT_O;
  endproperty
  a_timeout_off: assert property (p_timeout_off)
    else $error("Disabled timeout released the core.");

  property p_timeout_ends;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    timeout_ev |=> (!CPU_WAIT_O && timeout_reg);
  endproperty
  a_timeout_ends: assert property (p_timeout_ends)
    else $error("Timeout did not release the core.");

  property p_lock_read;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (lower_lock && XDATA_RD_I && in_lock_x) |=> XDATA_RDATA_O == 8'h00;
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("Locked low area readable by data path.");

  property p_free_open;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (idle && XDATA_WR_I && flash_we_reg && in_free_x) |=> CPU_WAIT_O;
  endproperty
  a_free_open: assert property (p_free_open)
    else $error("Free area store refused.");

  // Read-back is registered, so the flag is compared one cycle late.
  property p_area_readback;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (SFR_ADDR_I == AREA_UNLOCK_ADDR) |=>
      SFR_RDATA_O == {7'h00, $past(area_flag_reg)};
  endproperty
  a_area_readback: assert property (p_area_readback)
    else $error("Whole-area flag read back wrong.");

  property p_timeout_readback;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (SFR_ADDR_I == WRITE_UNLOCK_ADDR) |=>
      SFR_RDATA_O[TIMEOUT_BIT] == $past(timeout_reg);
  endproperty
  a_timeout_readback: assert property (p_timeout_readback)
    else $error("Timeout flag read back wrong.");

  property p_top_store;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (idle && XDATA_WR_I && xa > WRITE_TOP) |=> !CPU_WAIT_O;
  endproperty
  a_top_store: assert property (p_top_store)
    else $error("Store above the write range was accepted.");

  c_write_done: cover property (@(posedge CLK_I) prog_done);
  c_timeout:    cover property (@(posedge CLK_I) timeout_ev);
  c_area_write: cover property (@(posedge CLK_I) accept && in_main_x);
  c_no_timeout: cover property (@(posedge CLK_I) prog_done && tsel == 2'h0);
endmodule
`default_nettype wire

// [verification/fsw_core_model.sv]
// Core model issuing register, data and code accesses to the flash writer.
// Assumes one clock; every request is launched at a falling edge.
`timescale 1ns/100ps
`default_nettype none
module fsw_core_model (
  input  wire logic        clk_i,
  output var  logic [7:0]  sfr_addr_o,
  output var  logic [7:0]  sfr_wdata_o,
  output var  logic        sfr_wr_o,
  input  wire logic [7:0]  sfr_rdata_i,
  output var  logic [15:0] xaddr_o,
  output var  logic [7:0]  xwdata_o,
  output var  logic        xwr_o,
  output var  logic        xrd_o,
  input  wire logic [7:0]  xrdata_i,
  output var  logic [15:0] caddr_o,
  output var  logic        crd_o,
  input  wire logic [7:0]  crdata_i,
  output var  logic        volt_ok_o,
  input  wire logic        wait_i
);
  // Quiet buses at time zero with a healthy supply.
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
    sfr_wr_o = 1'b0;
    xaddr_o = 16'h0000;
    xwdata_o = 8'h00;
    xwr_o = 1'b0;
    xrd_o = 1'b0;
    caddr_o = 16'h0000;
    crd_o = 1'b0;
    volt_ok_o = 1'b1;
  end

  // Register write; stale data is inverted so nothing relies on it.
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_o = a;
    sfr_wdata_o = d;
    sfr_wr_o = 1'b1;
    @(negedge clk_i);
    sfr_wr_o = 1'b0;
    sfr_wdata_o = ~d;
  endtask

  // Register read; the answer is registered one cycle after the address.
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_o = a;
    @(negedge clk_i);
    d = sfr_rdata_i;
  endtask

  // Data or code read, answered in the next cycle.
  task automatic rd(input bit code, input logic [15:0] a,
                    output logic [7:0] d);
    @(negedge clk_i);
    xaddr_o = a;
    caddr_o = a;
    xrd_o = !code;
    crd_o = code;
    @(negedge clk_i);
    xrd_o = 1'b0;
    crd_o = 1'b0;
    d = code ? crdata_i : xrdata_i;
  endtask

  // Store; strobe and data drop after one cycle, then the core counts held cycles.
  task automatic store(input logic [15:0] a, input logic [7:0] d,
                       input int lim, output int n);
    @(negedge clk_i);
    xaddr_o = a;
    xwdata_o = d;
    xwr_o = 1'b1;
    @(negedge clk_i);
    xwr_o = 1'b0;
    xwdata_o = ~d;
    n = 0;
    while (wait_i === 1'b1 && n < lim) begin
      n++;
      @(negedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the flash self-write controller.
// Assumes the flash array starts unknown, so only written bytes are read.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int PROG = 20;
  localparam int TO1 = 40;
  localparam int TO2 = 60;
  localparam int TO3 = 80;
  logic clk, rst, swr, xwr, xrd, crd, vok, cwait, busy;
  logic [7:0] sa, swd, srd, xwd, xrdd, crdd;
  logic [15:0] xa, ca;
  int errors = 0;
  int n_compared = 0;
  int n;

  fsw_ctrl #(.PROG_CYCLES(PROG), .TO1_CYCLES(TO1), .TO2_CYCLES(TO2),
    .TO3_CYCLES(TO3)) fsw_ctrl_inst (.CLK_I(clk), .SYS_RST_I(rst),
    .SFR_ADDR_I(sa), .SFR_WDATA_I(swd), .SFR_WR_I(swr),
    .SFR_RDATA_O(srd), .XDATA_ADDR_I(xa), .XDATA_WDATA_I(xwd),
    .XDATA_WR_I(xwr), .XDATA_RD_I(xrd), .XDATA_RDATA_O(xrdd),
    .CODE_ADDR_I(ca), .CODE_RD_I(crd), .CODE_RDATA_O(crdd),
    .PGM_VOLTAGE_OK_I(vok), .CPU_WAIT_O(cwait), .PROG_BUSY_O(busy));
  fsw_core_model core (.clk_i(clk), .sfr_addr_o(sa), .sfr_wdata_o(swd),
    .sfr_wr_o(swr), .sfr_rdata_i(srd), .xaddr_o(xa), .xwdata_o(xwd),
    .xwr_o(xwr), .xrd_o(xrd), .xrdata_i(xrdd), .caddr_o(ca),
    .crd_o(crd), .crdata_i(crdd), .volt_ok_o(vok), .wait_i(cwait));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkn(string what, int exp, int got);
    n_compared++;
    if (got != exp) begin
      errors++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic rchk(logic [7:0] a, logic [7:0] exp);
    logic [7:0] d;
    core.sfr_rd(a, d);
    chk8("register", exp, d);
  endtask

  task automatic mchk(bit code, logic [15:0] a, logic [7:0] exp);
    logic [7:0] d;
    core.rd(code, a, d);
    chk8(code ? "code read" : "data read", exp, d);
  endtask

  // A limit far above every expected hold keeps a stuck wait bounded.
  task automatic stall(logic [15:0] a, logic [7:0] d, int exp);
    core.store(a, d, 500, n);
    chkn("held cycles", exp, n);
  endtask

  // Hang guard: the whole sequence needs well under 20000 cycles.
  initial begin
    #100000;
    errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rchk(8'hC9, 8'h00);
    rchk(8'h97, 8'h00);
    rchk(8'hF7, 8'h06);
    core.sfr_wr(8'h80, 8'h5A);
    rchk(8'h80, 8'h00);
    core.sfr_wr(8'hF7, 8'hFF);
    rchk(8'hF7, 8'hF7);
    core.sfr_wr(8'hC9, 8'hE2);
    rchk(8'hC9, 8'h20);
    core.sfr_wr(8'hC9, 8'h13);
    rchk(8'hC9, 8'h00);
    core.sfr_wr(8'h97, 8'hFF);
    rchk(8'h97, 8'h00);
    core.sfr_wr(8'h97, 8'h65);
    rchk(8'h97, 8'h01);
    core.sfr_wr(8'h97, 8'h64);
    rchk(8'h97, 8'h00);
    // Free area with the whole-area flag clear.
    stall(16'h3F01, 8'hA5, 0);
    core.sfr_wr(8'hC9, 8'h47);
    rchk(8'hC9, 8'h80);
    stall(16'h3F00, 8'h5A, PROG);
    core.sfr_wr(8'hC9, 8'h00);
    mchk(1'b0, 16'h3F00, 8'h5A);
    mchk(1'b1, 16'h3F00, 8'h5A);
    // Main area needs the whole-area flag for the data path.
    core.sfr_wr(8'hC9, 8'h47);
    core.sfr_wr(8'h97, 8'h65);
    stall(16'h2002, 8'hC3, PROG);
    core.sfr_wr(8'h97, 8'h00);
    stall(16'h2002, 8'h3C, 0);
    mchk(1'b0, 16'h2002, 8'h00);
    mchk(1'b1, 16'h2002, 8'hC3);
    mchk(1'b1, 16'h4000, 8'h00);
    stall(16'h3FF9, 8'h11, 0);
    core.sfr_wr(8'h97, 8'h65);
    mchk(1'b0, 16'h2002, 8'hC3);
    stall(16'h3FF8, 8'h11, PROG);
    mchk(1'b0, 16'h3FF8, 8'h11);
    stall(16'h3FFF, 8'h22, 0);
    mchk(1'b0, 16'h3FFF, 8'h00);
    core.sfr_wr(8'h97, 8'h00);
    mchk(1'b0, 16'h3FF8, 8'h00);
    core.sfr_wr(8'hC9, 8'h00);
    // Supply too low: each of timeout selects 01, 10 and 11 abandons the write.
    core.volt_ok_o = 1'b0;
    for (int s = 1; s < 4; s++) begin
      core.sfr_wr(8'hF7, 8'(s << 1));
      core.sfr_wr(8'hC9, 8'h47);
      stall(16'h3F00, 8'h77, s == 1 ? TO1 : s == 2 ? TO2 : TO3);
      rchk(8'hC9, 8'hC0);
      core.sfr_wr(8'hC9, 8'h00);
      rchk(8'hC9, 8'h00);
    end
    mchk(1'b0, 16'h3F00, 8'h5A);
    // Select 00 never gives up; the write ends once the supply recovers.
    core.sfr_wr(8'hF7, 8'h00);
    core.sfr_wr(8'hC9, 8'h47);
    core.store(16'h3F02, 8'h99, 100, n);
    chkn("held cycles", 100, n);
    chk8("busy", 8'h01, {7'h00, busy});
    core.volt_ok_o = 1'b1;
    n = 0;
    while (cwait === 1'b1 && n < 500) begin
      n++;
      @(negedge clk);
    end
    chkn("release cycles", 1, n);
    chk8("wait", 8'h00, {7'h00, cwait});
    chk8("busy", 8'h00, {7'h00, busy});
    rchk(8'hC9, 8'h80);
    core.sfr_wr(8'hC9, 8'h00);
    mchk(1'b0, 16'h3F02, 8'h99);
    summarize();
  end
endmodule
`default_nettype wire
